/* File: common/ips_pkg.sv */
package ips_pkg;

   // select register layout
   localparam int         SEL_WIDTH       = 7;
   localparam logic [7:0] SEL_RESET       = 8'h40;
   localparam int         SEL_BIT_TRIGGER = 0;
   localparam int         SEL_BIT_SCLK2   = 1;
   localparam int         SEL_BIT_SRX2    = 2;
   localparam int         SEL_BIT_EVENT   = 3;
   localparam int         SEL_BIT_SCLK    = 4;
   localparam int         SEL_BIT_SRX     = 5;
   localparam int         SEL_BIT_DEDIC   = 6;
   localparam int         SEL_BIT_RSVD    = 7;

   // register byte offsets
   localparam logic [7:0] OFFS_SELECT = 8'h00;
   localparam logic [7:0] OFFS_STATUS = 8'h04;
   localparam logic [7:0] OFFS_MASK   = 8'h08;
   localparam logic [7:0] OFFS_PINS   = 8'h0C;

   // sticky event bits
   localparam int EVT_RESELECT = 0;
   localparam int EVT_EDGE     = 1;
   localparam int EVT_COUNT    = 2;

   // pin status register layout
   localparam int PINS_BIT_LINE = 8;

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // channel edge polarity code meaning "no detection"
   localparam logic [1:0] POL_OFF = 2'h0;

   // bit order matches the select register, bit 6 down to bit 0
   typedef struct packed {
      logic dedicatedIrqPin;
      logic serialRxPin;
      logic serialClkPin;
      logic eventCountPin;
      logic secondSerialRxPin;
      logic secondSerialClkPin;
      logic triggerPin;
   } ips_pins_t;

   typedef struct packed {
      logic serialRxPin;
      logic serialClkPin;
      logic eventCountPin;
      logic secondSerialRxPin;
      logic secondSerialClkPin;
      logic triggerPin;
   } ips_periph_t;

   typedef enum logic [2:0] {
      REG_SEL  = 3'b000,
      REG_STAT = 3'b001,
      REG_MASK = 3'b010,
      REG_PINS = 3'b011,
      REG_NONE = 3'b100
   } ips_reg_t;

endpackage : ips_pkg

/* File: hw/ips_pin_mux.sv */
`timescale 1ns/1ps
module ips_pin_mux
   import ips_pkg::*;
(
   // selection
   input  wire logic [SEL_WIDTH-1:0] selBits,
   // raw pins
   input  wire ips_pins_t            pinIn,
   // channel 0 input of the edge detector
   output logic                      line
);

   logic [SEL_WIDTH-1:0] gated;

   // deselected pins contribute a constant low
   assign gated = selBits & pinIn;
   // any selected high pin drives the channel high
   assign line = |gated;

endmodule : ips_pin_mux

/* File: hw/ips_top.sv */
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ips_top
   import ips_pkg::*;
#(
   parameter int ADDR_W = 4
)(
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   // axi4-lite write data
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   // axi4-lite write response
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   // axi4-lite read data
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // peripheral input pins
   input  wire ips_pins_t         pinIn,
   // channel 0 state of the edge detector
   input  wire logic              requestEnableCh0,
   input  wire logic [1:0]        edgePolarityCh0,
   // channel 0 input and peripheral feeds
   output logic                   edgeCh0In,
   output ips_periph_t            periphOut,
   // interrupt
   output logic                   irq
);

   if (ADDR_W < 4) begin : g_addr_check
      $error("ADDR_W must be at least 4");
   end

   function automatic ips_reg_t decodeAddr(input logic [ADDR_W-1:0] addr);
      ips_reg_t r;
      r = REG_NONE;
      if (addr == ADDR_W'(OFFS_SELECT)) begin
         r = REG_SEL;
      end else if (addr == ADDR_W'(OFFS_STATUS)) begin
         r = REG_STAT;
      end else if (addr == ADDR_W'(OFFS_MASK)) begin
         r = REG_MASK;
      end else if (addr == ADDR_W'(OFFS_PINS)) begin
         r = REG_PINS;
      end
      return r;
   endfunction : decodeAddr

   logic [SEL_WIDTH-1:0] selReg;
   logic [EVT_COUNT-1:0] statusReg;
   logic [EVT_COUNT-1:0] maskReg;
   logic                 awHeld;
   logic                 wHeld;
   logic [ADDR_W-1:0]    wrAddr;
   logic [7:0]           wrData;
   logic                 wrLane;
   logic                 lineNow;
   logic                 linePrev;
   logic                 doWrite;
   ips_reg_t             wrTarget;
   logic                 selWrite;
   logic                 channelActive;
   logic [EVT_COUNT-1:0] evtSet;
   logic [EVT_COUNT-1:0] evtClr;
   logic [EVT_COUNT-1:0] next_status;
   logic [EVT_COUNT-1:0] next_mask;
   logic                 next_awHeld;
   logic                 next_wHeld;
   logic                 next_bvalid;
   logic                 next_rvalid;
   logic [31:0]          readData;
   logic [1:0]           readResp;
   logic                 rdIsSel;

   // selector path: no register between pins and channel 0
   ips_pin_mux u_mux (
      .selBits (selReg),
      .pinIn   (pinIn),
      .line    (lineNow)
   );

   // combinational on purpose: a flop would delay the wake edge
   assign edgeCh0In = lineNow;

   // peripherals keep their own inputs
   assign periphOut.serialRxPin        = pinIn.serialRxPin;
   assign periphOut.serialClkPin       = pinIn.serialClkPin;
   assign periphOut.eventCountPin      = pinIn.eventCountPin;
   assign periphOut.secondSerialRxPin  = pinIn.secondSerialRxPin;
   assign periphOut.secondSerialClkPin = pinIn.secondSerialClkPin;
   assign periphOut.triggerPin         = pinIn.triggerPin;

   // write channel bookkeeping
   assign doWrite  = awHeld & wHeld;
   assign wrTarget = decodeAddr(wrAddr);
   assign selWrite = doWrite && (wrTarget == REG_SEL) && wrLane;

   always_comb begin
      next_awHeld = doWrite ? 1'b0 : (awHeld | (awvalid & awready));
      next_wHeld  = doWrite ? 1'b0 : (wHeld | (wvalid & wready));
      if (doWrite) begin
         next_bvalid = 1'b1;
      end else if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end else begin
         next_bvalid = bvalid;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
      end else if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end else begin
         next_rvalid = rvalid;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         awHeld  <= 1'b0;
         wHeld   <= 1'b0;
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
      end else begin
         awHeld  <= next_awHeld;
         wHeld   <= next_wHeld;
         awready <= !next_awHeld && !next_bvalid && !doWrite;
         wready  <= !next_wHeld && !next_bvalid && !doWrite;
         bvalid  <= next_bvalid;
      end
   end

   // address and data may arrive in either order
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wrAddr <= '0;
         wrData <= 8'h00;
         wrLane <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            wrAddr <= awaddr;
         end
         if (wvalid && wready) begin
            wrData <= wdata[7:0];
            wrLane <= wstrb[0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bresp <= RESP_OKAY;
      end else if (doWrite) begin
         bresp <= (wrTarget == REG_NONE) ? RESP_DECERR : RESP_OKAY;
      end
   end

   // select register: bit 7 is never stored
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         selReg <= SEL_RESET[SEL_WIDTH-1:0];
      end else if (selWrite) begin
         selReg <= wrData[SEL_WIDTH-1:0];
      end
   end

   // events: reselect while the channel is live, and channel input rising
   assign channelActive        = requestEnableCh0 && (edgePolarityCh0 != POL_OFF);
   assign evtSet[EVT_RESELECT] = selWrite && channelActive;
   assign evtSet[EVT_EDGE]     = lineNow && !linePrev;
   assign evtClr = (doWrite && wrTarget == REG_STAT && wrLane) ? wrData[EVT_COUNT-1:0] : '0;
   // a new event wins over a clear in the same cycle
   assign next_status = (statusReg & ~evtClr) | evtSet;
   assign next_mask   = (doWrite && wrTarget == REG_MASK && wrLane) ? wrData[EVT_COUNT-1:0] : maskReg;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         linePrev <= 1'b0;
      end else begin
         linePrev <= lineNow;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         statusReg <= '0;
         maskReg   <= '0;
         irq       <= 1'b0;
      end else begin
         statusReg <= next_status;
         maskReg   <= next_mask;
         irq       <= |(next_status & next_mask);
      end
   end

   // read side
   always_comb begin
      readData = 32'h0000_0000;
      readResp = RESP_OKAY;
      unique case (decodeAddr(araddr))
         REG_SEL: begin
            readData = {25'h000_0000, selReg};
         end
         REG_STAT: begin
            readData = {30'h0000_0000, statusReg};
         end
         REG_MASK: begin
            readData = {30'h0000_0000, maskReg};
         end
         REG_PINS: begin
            readData = {23'h00_0000, lineNow, 1'b0, pinIn};
         end
         REG_NONE: begin
            readResp = RESP_DECERR;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
         rdIsSel <= 1'b0;
      end else begin
         arready <= !next_rvalid;
         rvalid  <= next_rvalid;
         if (arvalid && arready) begin
            rdata   <= readData;
            rresp   <= readResp;
            rdIsSel <= (decodeAddr(araddr) == REG_SEL);
         end
      end
   end

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_reset_select_value: assert property (
      $past(sys_rst) |-> selReg == SEL_RESET[SEL_WIDTH-1:0])
      else $error("select register not at reset value after reset");

   a_top_bit_reads_zero: assert property (
      rvalid && rdIsSel |-> rdata[SEL_BIT_RSVD] == 1'b0)
      else $error("select register top bit read as one");

   a_select_write_lands: assert property (
      selWrite |=> selReg == $past(wrData[SEL_WIDTH-1:0]) && bvalid)
      else $error("select write not applied in one cycle");

   a_line_is_or: assert property (
      edgeCh0In == |(selReg & pinIn))
      else $error("channel input differs from OR of selected pins");

   a_dedicated_deselected: assert property (
      !selReg[SEL_BIT_DEDIC] && pinIn.dedicatedIrqPin && (selReg & pinIn) == '0 |-> !edgeCh0In)
      else $error("deselected pins still drive the channel");

   a_dedicated_passes: assert property (
      selReg[SEL_BIT_DEDIC] && pinIn.dedicatedIrqPin |-> edgeCh0In)
      else $error("selected dedicated pin did not reach the channel");

   a_serial_rx_passes: assert property (
      selReg[SEL_BIT_SRX] && pinIn.serialRxPin |-> edgeCh0In)
      else $error("selected serial receive pin did not reach the channel");

   a_low_bits_pass: assert property (
      (selReg[SEL_BIT_TRIGGER] && pinIn.triggerPin) || (selReg[SEL_BIT_SCLK] && pinIn.serialClkPin)
      || (selReg[SEL_BIT_EVENT] && pinIn.eventCountPin) || (selReg[SEL_BIT_SRX2] && pinIn.secondSerialRxPin)
      || (selReg[SEL_BIT_SCLK2] && pinIn.secondSerialClkPin) |-> edgeCh0In)
      else $error("selected low pin did not reach the channel");

   a_or_of_two: assert property (
      selReg[SEL_BIT_TRIGGER] && selReg[SEL_BIT_DEDIC] && !pinIn.dedicatedIrqPin && pinIn.triggerPin
      |-> edgeCh0In)
      else $error("OR of two selected pins failed");

   a_periph_unchanged: assert property (
      periphOut == {pinIn.serialRxPin, pinIn.serialClkPin, pinIn.eventCountPin,
                    pinIn.secondSerialRxPin, pinIn.secondSerialClkPin, pinIn.triggerPin})
      else $error("peripheral feed altered");

   a_reselect_flagged: assert property (
      selWrite && channelActive |=> statusReg[EVT_RESELECT]
      && irq == (maskReg[EVT_RESELECT] || (statusReg[EVT_EDGE] && maskReg[EVT_EDGE])))
      else $error("reselect while channel live not flagged");

   a_edge_event_kept: assert property (
      lineNow && !linePrev |=> statusReg[EVT_EDGE])
      else $error("rising channel input lost");

   a_irq_level: assert property (
      irq == |(statusReg & maskReg))
      else $error("interrupt output disagrees with status and mask");

   a_write_answer: assert property (
      doWrite |=> bvalid ##0 bresp == ($past(wrTarget) == REG_NONE ? RESP_DECERR : RESP_OKAY))
      else $error("write answer missing or wrong");

   a_read_answer: assert property (
      arvalid && arready |=> rvalid && !arready)
      else $error("read answer not one cycle after address");

   a_write_stall: assert property (
      bvalid |-> !awready && !wready)
      else $error("new write accepted while answer pending");

endmodule : ips_top

/* File: bench/ips_edge_model.sv */
`timescale 1ns/1ps
module ips_edge_model
   import ips_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // selector output
   input  wire logic       line,
   // software settings
   input  wire logic [1:0] cfgPol,
   input  wire logic       cfgEn,
   input  wire logic       clrFlag,
   // channel 0 state
   output logic            requestEnableCh0,
   output logic [1:0]      edgePolarityCh0,
   output logic            flag
);
   logic lineQ;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         requestEnableCh0 <= 1'b0;
         edgePolarityCh0  <= POL_OFF;
         flag             <= 1'b0;
         lineQ            <= 1'b0;
      end else begin
         lineQ            <= line;
         requestEnableCh0 <= cfgEn;
         // polarity only taken while the channel is off
         if (!requestEnableCh0 && !cfgEn) begin
            edgePolarityCh0 <= cfgPol;
         end
         if (clrFlag) begin
            flag <= 1'b0;
         end else if ((edgePolarityCh0[0] && line && !lineQ) || (edgePolarityCh0[1] && !line && lineQ)) begin
            flag <= 1'b1;
         end
      end
   end
endmodule : ips_edge_model

/* File: bench/tb_interrupt_pin_selector.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module tb_interrupt_pin_selector;
   import ips_pkg::*;

   logic        sys_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq, edgeCh0In;
   logic        requestEnableCh0, flag, cfgEn, clrFlag;
   logic [1:0]  bresp, rresp, edgePolarityCh0, cfgPol, resp;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, rd;
   ips_pins_t   pinIn;
   ips_periph_t periphOut;
   int          err_total, checked, cyc;

   ips_top #(.ADDR_W(4)) dut (.sys_clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pinIn,
      .requestEnableCh0, .edgePolarityCh0, .edgeCh0In, .periphOut, .irq);

   ips_edge_model partner (.sys_clk, .sys_rst, .line(edgeCh0In), .cfgPol, .cfgEn, .clrFlag, .requestEnableCh0,
      .edgePolarityCh0, .flag);

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      if (err_total == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic ad;
      logic dd;
      ad = 1'b0;
      dd = 1'b0;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge sys_clk);
         if (!ad && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!dd && wready) begin
            dd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge sys_clk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
      @(posedge sys_clk);
   endtask : wr

   task automatic rdr(input logic [3:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge sys_clk);
   endtask : rdr

   // drive pins, check the combinational paths in the same cycle
   task automatic pchk(input logic [6:0] v, input logic e);
      pinIn <= ips_pins_t'(v);
      #1;
      `CHK(edgeCh0In, e)
      `CHK(periphOut, ips_periph_t'(v[5:0]))
      @(posedge sys_clk);
   endtask : pchk

   task automatic t_reset;
      rdr(OFFS_SELECT[3:0]);
      `CHK(rd, 32'h40)
      rdr(OFFS_MASK[3:0]);
      `CHK(rd, 32'h0)
      pchk(7'h3F, 1'b0);
      pchk(7'h40, 1'b1);
      wr(OFFS_SELECT[3:0], 32'hFFFFFFFF);
      `CHK(resp, RESP_OKAY)
      rdr(OFFS_SELECT[3:0]);
      `CHK(rd, 32'h7F)
   endtask : t_reset

   task automatic t_bits;
      for (int i = 0; i < SEL_WIDTH; i++) begin
         wr(OFFS_SELECT[3:0], 32'h1 << i);
         pchk(7'h1 << i, 1'b1);
         pchk(~(7'h1 << i), 1'b0);
      end
   endtask : t_bits

   task automatic t_or;
      wr(OFFS_SELECT[3:0], 32'h21);
      pchk(7'h20, 1'b1);
      pchk(7'h01, 1'b1);
      pchk(7'h21, 1'b1);
      // pin status: line in bit 8, raw pins below
      rdr(OFFS_PINS[3:0]);
      `CHK(rd, 32'h121)
      pchk(7'h5E, 1'b0);
   endtask : t_or

   task automatic t_flow;
      pchk(7'h00, 1'b0);
      wr(OFFS_SELECT[3:0], 32'h01);
      wr(OFFS_STATUS[3:0], 32'h3);
      rdr(OFFS_STATUS[3:0]);
      `CHK(rd, 32'h0)
      cfgPol <= 2'h1;
      @(posedge sys_clk);
      clrFlag <= 1'b1;
      @(posedge sys_clk);
      clrFlag <= 1'b0;
      cfgEn   <= 1'b1;
      wr(OFFS_MASK[3:0], 32'h2);
      `CHK(irq, 1'b0)
      pchk(7'h01, 1'b1);
      repeat (2) @(posedge sys_clk);
      `CHK(flag, 1'b1)
      `CHK(irq, 1'b1)
      rdr(OFFS_STATUS[3:0]);
      `CHK(rd, 32'h2)
      wr(OFFS_STATUS[3:0], 32'h2);
      `CHK(irq, 1'b0)
      // reselect while the channel is live is flagged
      wr(OFFS_SELECT[3:0], 32'h41);
      wr(OFFS_MASK[3:0], 32'h1);
      rdr(OFFS_STATUS[3:0]);
      `CHK(rd, 32'h1)
      `CHK(irq, 1'b1)
      cfgEn   <= 1'b0;
      clrFlag <= 1'b1;
      @(posedge sys_clk);
      clrFlag <= 1'b0;
   endtask : t_flow

   task automatic t_decerr;
      wr(4'h2, 32'h0);
      `CHK(resp, RESP_DECERR)
      rdr(4'hE);
      `CHK(resp, RESP_DECERR)
      `CHK(rd, 32'h0)
      // byte lane 0 off: write answered but not applied
      wstrb <= 4'hE;
      wr(OFFS_SELECT[3:0], 32'h0);
      `CHK(resp, RESP_OKAY)
      wstrb <= 4'hF;
      rdr(OFFS_SELECT[3:0]);
      `CHK(rd, 32'h41)
   endtask : t_decerr

   // reset in mid-run restores the selection and drops the interrupt
   task automatic t_rerun;
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      `CHK(irq, 1'b0)
      `CHK(edgeCh0In, 1'b0)
      rdr(OFFS_SELECT[3:0]);
      `CHK(rd, 32'h40)
   endtask : t_rerun

   initial begin
      sys_rst   = 1'b1;
      awvalid   = 1'b0;
      wvalid    = 1'b0;
      bready    = 1'b0;
      arvalid   = 1'b0;
      rready    = 1'b0;
      awaddr    = 4'h0;
      araddr    = 4'h0;
      wdata     = 32'h0;
      wstrb     = 4'hF;
      pinIn     = '0;
      cfgPol    = 2'h0;
      cfgEn     = 1'b0;
      clrFlag   = 1'b0;
      err_total = 0;
      checked   = 0;
      cyc       = 0;
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_bits();
      t_or();
      t_flow();
      t_decerr();
      t_rerun();
      give_verdict();
   end
endmodule : tb_interrupt_pin_selector
